// File: logic/irqrs_pkg.sv
package irqrs_pkg;

  // register byte addresses on the wishbone slave
  localparam logic [7:0] ADR_EXT_IRQ_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] ADR_SRS = 8'h04;
  localparam logic [7:0] ADR_FORCE = 8'h08;

  // bit positions of the status/control byte
  localparam int EXT_IRQ_STATUS_CONTROL_PDD_BIT = 6;
  localparam int EXT_IRQ_STATUS_CONTROL_EDG_BIT = 5;
  localparam int EXT_IRQ_STATUS_CONTROL_PE_BIT = 4;
  localparam int EXT_IRQ_STATUS_CONTROL_FLAG_BIT = 3;
  localparam int EXT_IRQ_STATUS_CONTROL_ACK_BIT = 2;
  localparam int EXT_IRQ_STATUS_CONTROL_IE_BIT = 1;
  localparam int EXT_IRQ_STATUS_CONTROL_MODE_BIT = 0;

  // bit positions of the reset source byte and of the force register
  localparam int SRS_POR_BIT = 7;
  localparam int SRS_PIN_BIT = 6;
  localparam int SRS_WDOG_BIT = 5;
  localparam int SRS_OPC_BIT = 4;
  localparam int SRS_ADR_BIT = 3;
  localparam int SRS_LV_BIT = 1;
  localparam int FORCE_BIT = 0;

  // values after reset
  localparam logic [7:0] EXT_IRQ_STATUS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SRS_POR_VALUE = 8'h82;
  localparam logic [7:0] FORCE_READ_VALUE = 8'h00;

  // cycles a requested system reset is held at least
  localparam logic [3:0] RESET_HOLD_CYCLES = 4'h8;

  typedef struct packed {
    logic pull_device_disable;
    logic polarity_select;
    logic ext_int_pin_enable;
    logic ext_int_request_enable;
    logic detection_mode;
  } irqrs_ctrl_t;

  typedef struct packed {
    logic power_on;
    logic pin;
    logic watchdog_reset_flag;
    logic bad_opcode_reset_flag;
    logic bad_address_reset_flag;
    logic low_voltage_reset_flag;
  } irqrs_srs_t;

  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_HOLD = 1'b1
  } irqrs_state_t;

endpackage : irqrs_pkg

// File: logic/irqrs_top.sv
// Function
// - pull device on while pin enabled and pull disable bit is zero
// - polarity bit: zero falling/low, one rising/high
// - rising polarity turns the pull device into a pulldown
// - pin enable bit gates pin event detection, not the level-mode ack block
// - event flag set by detected pin events only, read-only to software
// - writing one to acknowledge clears the flag; ack reads zero
// - in level mode acknowledge fails while pin stays asserted
// - request output follows flag while interrupt enable is one
// - mode bit: zero edges only, one edges and levels
// - reset status is read-only with fixed bit layout, bits 2 and 0 zero
// - any write to reset status restarts watchdog, flags unchanged
// - debug forced reset leaves all status flags cleared; other causes active at entry still set their flags
// - power-on reset sets power-on and low-voltage flags only
// - low-voltage reset sets its flag, keeps power-on, clears rest
// - other resets set flags of every source active at entry
// - pin flag records reset by low level on reset pin
// - watchdog flag records timeout; no watchdog reset when disabled
// - bad opcode reset on unimplemented, disallowed stop or background op
// - unimplemented address access resets and sets the address flag
// - force register ignores user writes, debug writes only; reads zero
// - debug write of one to force bit resets the device at once
//
// The register addresses and the Wishbone interface to the registers were decided locally.
module irqrs_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic dbg_wr_i,
  input wire logic [7:0] dbg_adr_i,
  input wire logic [7:0] dbg_dat_i,
  input wire logic irq_pin_i,
  input wire logic reset_pin_n_i,
  input wire logic lvd_trip_i,
  input wire logic low_voltage_reset_enable_i,
  input wire logic watchdog_timeout_i,
  input wire logic watchdog_enable_i,
  input wire logic unimpl_opcode_i,
  input wire logic stop_exec_i,
  input wire logic stop_allowed_i,
  input wire logic background_instruction_exec_i,
  input wire logic background_mode_allowed_i,
  input wire logic bad_address_i,
  output logic irq_req_o,
  output logic pullup_en_o,
  output logic pulldown_en_o,
  output logic watchdog_refresh_o,
  output logic sys_reset_o
);
  import irqrs_pkg::*;

  irqrs_ctrl_t ctrl;
  irqrs_srs_t reset_source_status;
  irqrs_state_t state;
  logic ext_int_event_flag;
  logic [3:0] hold_cnt;
  logic [1:0] irq_sync;
  logic [1:0] rpin_sync;
  logic asserted_prev;
  logic asserted;
  logic pin_event;
  logic req;
  logic wr_fire;
  logic [7:0] rd_byte;
  logic c_pin;
  logic c_wdog;
  logic c_opc;
  logic c_adr;
  logic c_lv;
  logic c_force;
  logic enter;
  logic in_reset;
  logic [1:0] async_in;
  irqrs_srs_t next_srs;
  irqrs_state_t next_state;
  logic [3:0] next_hold_cnt;
  logic next_sys_reset;
  logic next_flag;
  logic ack_hit;

  // one address compare behind every register write strobe, so the bus
  // qualification (cyc, stb, we, ack and lane 0) lives in wr_fire alone
  function automatic logic reg_write_hit(input logic fire,
                                         input logic [7:0] a,
                                         input logic [7:0] target);
    reg_write_hit = fire & (a == target);
  endfunction : reg_write_hit

  // status/control byte as software sees it; the acknowledge bit is
  // write-only and never reads back
  function automatic logic [7:0] pack_ext_irq_status_control(input irqrs_ctrl_t c,
                                            input logic flag);
    logic [7:0] b;
    b = 8'h00;
    b[EXT_IRQ_STATUS_CONTROL_PDD_BIT] = c.pull_device_disable;
    b[EXT_IRQ_STATUS_CONTROL_EDG_BIT] = c.polarity_select;
    b[EXT_IRQ_STATUS_CONTROL_PE_BIT] = c.ext_int_pin_enable;
    b[EXT_IRQ_STATUS_CONTROL_FLAG_BIT] = flag;
    b[EXT_IRQ_STATUS_CONTROL_ACK_BIT] = 1'b0;
    b[EXT_IRQ_STATUS_CONTROL_IE_BIT] = c.ext_int_request_enable;
    b[EXT_IRQ_STATUS_CONTROL_MODE_BIT] = c.detection_mode;
    pack_ext_irq_status_control = b;
  endfunction : pack_ext_irq_status_control

  // reset source byte; bits 2 and 0 have no flag behind them
  function automatic logic [7:0] pack_srs(input irqrs_srs_t s);
    logic [7:0] b;
    b = 8'h00;
    b[SRS_POR_BIT] = s.power_on;
    b[SRS_PIN_BIT] = s.pin;
    b[SRS_WDOG_BIT] = s.watchdog_reset_flag;
    b[SRS_OPC_BIT] = s.bad_opcode_reset_flag;
    b[SRS_ADR_BIT] = s.bad_address_reset_flag;
    b[SRS_LV_BIT] = s.low_voltage_reset_flag;
    pack_srs = b;
  endfunction : pack_srs

  // second stage only feeds logic; first stage is read by nothing else;
  // the reset pin stages start high so reset release shows no pin cause
  for (genvar g = 0; g < 2; g++) begin : g_sync
    logic [1:0] stage;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        stage <= (g == 1) ? 2'h3 : 2'h0;
      end else begin
        stage <= {stage[0], async_in[g]};
      end
    end
  end

  always_comb begin
    async_in = {reset_pin_n_i, irq_pin_i};
    irq_sync = g_sync[0].stage;
    rpin_sync = g_sync[1].stage;
  end

  always_comb begin
    asserted = ctrl.polarity_select ? irq_sync[1] : ~irq_sync[1];
    pin_event = ctrl.ext_int_pin_enable &
      ((asserted & ~asserted_prev) | (ctrl.detection_mode & asserted));
  end

  // reset cause qualification
  always_comb begin
    c_pin = ~rpin_sync[1];
    c_wdog = watchdog_timeout_i & watchdog_enable_i;
    c_opc = unimpl_opcode_i | (stop_exec_i & ~stop_allowed_i) |
      (background_instruction_exec_i & ~background_mode_allowed_i);
    c_adr = bad_address_i;
    c_lv = lvd_trip_i & low_voltage_reset_enable_i;
    c_force = dbg_wr_i & (dbg_adr_i == ADR_FORCE) & dbg_dat_i[FORCE_BIT];
    enter = (state == ST_RUN) &
      (c_pin | c_wdog | c_opc | c_adr | c_lv | c_force);
    in_reset = enter | (state == ST_HOLD);
  end

  // reset sequencer: holds sys_reset_o for the hold count, then while the pin or low-voltage cause persists
  always_comb begin
    next_state = state;
    next_hold_cnt = hold_cnt;
    next_sys_reset = sys_reset_o;
    if (enter) begin
      next_state = ST_HOLD;
      next_hold_cnt = RESET_HOLD_CYCLES;
      next_sys_reset = 1'b1;
    end else if (state == ST_HOLD) begin
      if (hold_cnt != 4'h0) begin
        next_hold_cnt = hold_cnt - 4'h1;
      end else if (!c_pin && !c_lv) begin
        // the pin and the low-voltage trip keep the device in reset
        // for as long as they stay active
        next_state = ST_RUN;
        next_sys_reset = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_HOLD;
      hold_cnt <= RESET_HOLD_CYCLES;
      sys_reset_o <= 1'b1;
    end else begin
      state <= next_state;
      hold_cnt <= next_hold_cnt;
      sys_reset_o <= next_sys_reset;
    end
  end

  // reset source status, loaded only at reset entry
  always_comb begin
    next_srs = reset_source_status;
    if (enter) begin
      if (c_lv) begin
        next_srs = '{power_on: reset_source_status.power_on, low_voltage_reset_flag: 1'b1,
                     default: 1'b0};
      end else begin
        // a lone debug force sets nothing, so all flags end cleared
        next_srs.power_on = 1'b0;
        next_srs.low_voltage_reset_flag = 1'b0;
        next_srs.pin = c_pin;
        next_srs.watchdog_reset_flag = c_wdog;
        next_srs.bad_opcode_reset_flag = c_opc;
        next_srs.bad_address_reset_flag = c_adr;
      end
    end
  end

  // causes seen while reset is already held are not recorded, so the
  // byte always names what started the current reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_source_status <= '{power_on: 1'b1, low_voltage_reset_flag: 1'b1,
               default: 1'b0};
    end else begin
      reset_source_status <= next_srs;
    end
  end

  // wishbone classic: ack one cycle after the request, write on ack edge
  always_comb begin
    req = cyc_i & stb_i;
    wr_fire = req & we_i & ack_o & sel_i[0];
  end

  always_comb begin
    rd_byte = 8'h00;
    unique case (adr_i)
      ADR_EXT_IRQ_STATUS_CONTROL: rd_byte = pack_ext_irq_status_control(ctrl, ext_int_event_flag);
      ADR_SRS: rd_byte = pack_srs(reset_source_status);
      ADR_FORCE: rd_byte = FORCE_READ_VALUE;
      default: rd_byte = 8'h00;
    endcase
  end

  // ack drops in the cycle after it was given even if the master still
  // holds its request, and a request still held is acked again one cycle later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req & ~ack_o;
    end
  end

  // read data stands only beside ack and is zero otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else begin
      dat_o <= (req & ~ack_o & ~we_i) ? {24'h0, rd_byte} : 32'h0;
    end
  end

  // an srs write only pulses the refresh; flags are untouched
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      watchdog_refresh_o <= 1'b0;
    end else begin
      watchdog_refresh_o <= reg_write_hit(wr_fire, adr_i, ADR_SRS);
    end
  end

  // control bits; cleared by every system reset
  always_ff @(posedge clk_i) begin
    if (rst_i || in_reset) begin
      ctrl <= irqrs_ctrl_t'(5'h00);
    end else if (reg_write_hit(wr_fire, adr_i, ADR_EXT_IRQ_STATUS_CONTROL)) begin
      ctrl.pull_device_disable <= dat_i[EXT_IRQ_STATUS_CONTROL_PDD_BIT];
      ctrl.polarity_select <= dat_i[EXT_IRQ_STATUS_CONTROL_EDG_BIT];
      ctrl.ext_int_pin_enable <= dat_i[EXT_IRQ_STATUS_CONTROL_PE_BIT];
      ctrl.ext_int_request_enable <= dat_i[EXT_IRQ_STATUS_CONTROL_IE_BIT];
      ctrl.detection_mode <= dat_i[EXT_IRQ_STATUS_CONTROL_MODE_BIT];
    end
  end

  // event flag: a detected event wins over a same-cycle acknowledge
  always_comb begin
    ack_hit = reg_write_hit(wr_fire, adr_i, ADR_EXT_IRQ_STATUS_CONTROL) &
      dat_i[EXT_IRQ_STATUS_CONTROL_ACK_BIT];
    next_flag = ext_int_event_flag;
    if (pin_event) begin
      next_flag = 1'b1;
    end else if (ack_hit && !(ctrl.detection_mode && asserted)) begin
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || in_reset) begin
      ext_int_event_flag <= 1'b0;
    end else begin
      ext_int_event_flag <= next_flag;
    end
  end

  // edge memory starts asserted so a pin already active at reset release
  // raises no edge event
  always_ff @(posedge clk_i) begin
    if (rst_i || in_reset) begin
      asserted_prev <= 1'b1;
    end else begin
      asserted_prev <= asserted;
    end
  end

  // request lags the flag by one cycle, traded for a clean flop output
  always_ff @(posedge clk_i) begin
    if (rst_i || in_reset) begin
      irq_req_o <= 1'b0;
    end else begin
      irq_req_o <= ext_int_event_flag & ctrl.ext_int_request_enable;
    end
  end

  // the polarity picks the pull so an open pin idles deasserted
  always_ff @(posedge clk_i) begin
    if (rst_i || in_reset) begin
      pullup_en_o <= 1'b0;
      pulldown_en_o <= 1'b0;
    end else begin
      pullup_en_o <= ctrl.ext_int_pin_enable &
        ~ctrl.pull_device_disable & ~ctrl.polarity_select;
      pulldown_en_o <= ctrl.ext_int_pin_enable &
        ~ctrl.pull_device_disable & ctrl.polarity_select;
    end
  end

endmodule : irqrs_top

// File: verification/irqrs_sva.sv
module irqrs_sva
  import irqrs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  input wire logic dbg_wr_i,
  input wire logic [7:0] dbg_adr_i,
  input wire logic [7:0] dbg_dat_i,
  input wire logic reset_pin_n_i,
  input wire logic watchdog_timeout_i,
  input wire logic watchdog_enable_i,
  input wire logic irq_req_o,
  input wire logic pullup_en_o,
  input wire logic pulldown_en_o,
  input wire logic watchdog_refresh_o,
  input wire logic sys_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_force_resets: assert property (!sys_reset_o && dbg_wr_i &&
    dbg_adr_i == ADR_FORCE && dbg_dat_i[0] |=> sys_reset_o)
    else $error("debug force gave no reset");
  a_reset_held: assert property ($rose(sys_reset_o) |->
    sys_reset_o [*8]) else $error("system reset too short");
  a_wdog_resets: assert property (!sys_reset_o &&
    watchdog_timeout_i && watchdog_enable_i |=> sys_reset_o)
    else $error("enabled timeout gave no reset");
  a_pin_resets: assert property (!reset_pin_n_i [*3] |=>
    sys_reset_o) else $error("reset pin ignored");
  a_refresh_pulse: assert property (ack_o && we_i && sel_i[0] &&
    adr_i == ADR_SRS |-> ##[1:2] watchdog_refresh_o)
    else $error("no watchdog refresh");
  a_force_reads_zero: assert property (ack_o && !we_i &&
    adr_i == ADR_FORCE |-> dat_o == 32'h0) else $error("force read");
  a_srs_reserved: assert property (ack_o && !we_i &&
    adr_i == ADR_SRS |-> dat_o[2] == 1'b0 && dat_o[0] == 1'b0 &&
    dat_o[31:8] == 24'h0) else $error("status reserved bits");
  a_ack_reads_zero: assert property (ack_o && !we_i &&
    adr_i == ADR_EXT_IRQ_STATUS_CONTROL |-> !dat_o[EXT_IRQ_STATUS_CONTROL_ACK_BIT])
    else $error("acknowledge bit read one");
  a_pull_exclusive: assert property (!(pullup_en_o &&
    pulldown_en_o)) else $error("both pull devices on");
  a_quiet_reset: assert property (sys_reset_o [*3] |-> !irq_req_o &&
    !pullup_en_o && !pulldown_en_o) else $error("pin logic live in reset");
endmodule : irqrs_sva

bind irqrs_top irqrs_sva u_irqrs_sva (.*);

// File: verification/irqrs_partner.sv
module irqrs_partner (
  input wire logic clk_i,
  output logic pin_o = 1'b0,
  output logic wr_o = 1'b0,
  output logic [7:0] adr_o = 8'h08,
  output logic [7:0] dat_o = 8'h01,
  output logic mode_sel_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy = 1'b0;
  // idle byte keeps flipping so only the strobe may qualify it
  always @(posedge clk_i) if (!busy) dat_o <= ~dat_o;
  task automatic drive_pin(input logic v);
    @(posedge clk_i);
    pin_o <= v;
  endtask : drive_pin
  task automatic force_reset;
    busy = 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b1;
    dat_o <= 8'h01;
    @(posedge clk_i);
    wr_o <= 1'b0;
    mode_sel_o <= 1'b1;
    busy = 1'b0;
  endtask : force_reset
endmodule : irqrs_partner

// File: verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import irqrs_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00, dadr, ddat;
  logic [31:0] wd = 32'h0, dat_o;
  logic [8:0] src = 9'h000;
  logic [3:0] sel = 4'h1;
  logic allow = 1'b0;
  logic ack_o, irq_req_o, pu, pd, refresh, sys_rst, pin, dwr;
  int error_cnt = 0, cmp_count = 0, refr = 0;
  logic [8:0] cs [10] = '{9'h001, 9'h003, 9'h040, 9'h004, 9'h080,
    9'h018, 9'h100, 9'h020, 9'h120, 9'h008};
  logic [7:0] ex [10] = '{8'h00, 8'h20, 8'h10, 8'h40, 8'h10,
    8'h02, 8'h10, 8'h08, 8'h18, 8'h18};
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (refresh) refr <= refr + 1;
  irqrs_top u_irqrs_top (.clk_i, .rst_i, .adr_i(adr), .dat_i(wd),
    .dat_o, .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(cyc), .ack_o,
    .dbg_wr_i(dwr), .dbg_adr_i(dadr), .dbg_dat_i(ddat), .irq_pin_i(pin),
    .reset_pin_n_i(~src[2]), .lvd_trip_i(src[3]),
    .low_voltage_reset_enable_i(src[4]), .watchdog_timeout_i(src[0]),
    .watchdog_enable_i(src[1]), .unimpl_opcode_i(src[8]),
    .stop_exec_i(src[6]), .stop_allowed_i(allow), .background_instruction_exec_i(src[7]),
    .background_mode_allowed_i(allow), .bad_address_i(src[5]),
    .irq_req_o, .pullup_en_o(pu), .pulldown_en_o(pd),
    .watchdog_refresh_o(refresh), .sys_reset_o(sys_rst));
  irqrs_partner u_irqrs_partner (.clk_i, .pin_o(pin), .wr_o(dwr),
    .adr_o(dadr), .dat_o(ddat), .mode_sel_o());
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    cyc <= 1'b0;
    if (n >= 50) error_cnt++;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, {24'h0, e});
  endtask : rd
  task automatic waitc(input int k);
    repeat (k) @(posedge clk_i);
  endtask : waitc
  // bounded wait for the internal reset hold to end
  task automatic settle;
    int n;
    n = 0;
    while (sys_rst !== 1'b0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk(sys_rst, 1'b0);
  endtask : settle
  task automatic final_report;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  initial begin
    #100us;
    error_cnt++;
    final_report();
  end
  initial begin
    waitc(2);
    rst_i <= 1'b0;
    rd(ADR_SRS, SRS_POR_VALUE);
    wr(ADR_SRS, 8'hff);
    rd(ADR_SRS, SRS_POR_VALUE);
    chk(refr, 1);
    settle();
    rd(ADR_EXT_IRQ_STATUS_CONTROL, EXT_IRQ_STATUS_CONTROL_RESET);
    rd(8'h0c, 8'h00);
    wr(ADR_FORCE, 8'h01);
    waitc(3);
    chk(sys_rst, 1'b0);
    rd(ADR_FORCE, FORCE_READ_VALUE);
    wr(ADR_EXT_IRQ_STATUS_CONTROL, 8'h32);
    rd(ADR_EXT_IRQ_STATUS_CONTROL, 8'h32);
    chk({pu, pd}, 2'b01);
    wr(ADR_EXT_IRQ_STATUS_CONTROL, 8'h72);
    waitc(2);
    chk({pu, pd}, 2'b00);
    u_irqrs_partner.drive_pin(1'b1);
    waitc(5);
    rd(ADR_EXT_IRQ_STATUS_CONTROL, 8'h7a);
    chk(irq_req_o, 1'b1);
    wr(ADR_EXT_IRQ_STATUS_CONTROL, 8'h76);
    rd(ADR_EXT_IRQ_STATUS_CONTROL, 8'h72);
    wr(ADR_EXT_IRQ_STATUS_CONTROL, 8'h73);
    waitc(5);
    wr(ADR_EXT_IRQ_STATUS_CONTROL, 8'h77);
    rd(ADR_EXT_IRQ_STATUS_CONTROL, 8'h7b);
    u_irqrs_partner.drive_pin(1'b0);
    waitc(5);
    wr(ADR_EXT_IRQ_STATUS_CONTROL, 8'h77);
    rd(ADR_EXT_IRQ_STATUS_CONTROL, 8'h73);
    chk(irq_req_o, 1'b0);
    wr(ADR_EXT_IRQ_STATUS_CONTROL, 8'h10);
    waitc(2);
    chk({pu, pd}, 2'b10);
    wr(ADR_EXT_IRQ_STATUS_CONTROL, 8'h66);
    u_irqrs_partner.drive_pin(1'b1);
    waitc(5);
    rd(ADR_EXT_IRQ_STATUS_CONTROL, 8'h62);
    u_irqrs_partner.drive_pin(1'b0);
    u_irqrs_partner.force_reset();
    waitc(2);
    chk(sys_rst, 1'b1);
    settle();
    rd(ADR_SRS, 8'h00);
    rd(ADR_EXT_IRQ_STATUS_CONTROL, EXT_IRQ_STATUS_CONTROL_RESET);
    for (int i = 0; i < 10; i++) begin
      src <= cs[i];
      waitc(4);
      src <= 9'h000;
      settle();
      rd(ADR_SRS, ex[i]);
    end
    allow <= 1'b1;
    src <= 9'h0c0;
    waitc(4);
    src <= 9'h000;
    waitc(4);
    chk(sys_rst, 1'b0);
    rd(ADR_SRS, 8'h18);
    sel <= 4'h0;
    wr(ADR_EXT_IRQ_STATUS_CONTROL, 8'h73);
    sel <= 4'h1;
    rd(ADR_EXT_IRQ_STATUS_CONTROL, EXT_IRQ_STATUS_CONTROL_RESET);
    final_report();
  end
endmodule : testbench
